// ### rtl/umcr_pkg.sv
// Constants for the serial port mode and control register block.
// Assumes a 32-bit AXI4-Lite register bus and a single 40 MHz clock.
package umcr_pkg;
   // Register map (byte addresses)
   localparam logic [7:0]  MODE_OFFSET     = 8'h00;
   localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
   // Software-writable positions; unimplemented and read-only bits are zero
   localparam logic [31:0] MODE_WRITE_MASK = 32'h0087_BBFF;
   // Field positions
   localparam int SLEEP_RUN_POS    = 23;
   localparam int ACTIVE_POS       = 22;
   localparam int CLK_SRC_HI_POS   = 18;
   localparam int CLK_SRC_LO_POS   = 17;
   localparam int RUN_OVR_POS      = 16;
   localparam int MODULE_ON_POS    = 15;
   localparam int IDLE_STOP_POS    = 13;
   localparam int IR_ENABLE_POS    = 12;
   localparam int RTS_MODE_POS     = 11;
   localparam int PIN_EN_HI_POS    = 9;
   localparam int PIN_EN_LO_POS    = 8;
   localparam int WAKE_POS         = 7;
   localparam int LOOPBACK_POS     = 6;
   localparam int AUTO_BAUD_POS    = 5;
   localparam int RX_INVERT_POS    = 4;
   localparam int HIGH_SPEED_POS   = 3;
   localparam int PARITY_HI_POS    = 2;
   localparam int PARITY_LO_POS    = 1;
   localparam int STOP_BIT_POS     = 0;
   // Baud clock source codes
   typedef enum logic [1:0] {
      SRC_BUS2_SLEEPOFF = 2'b00,
      SRC_SYSTEM        = 2'b01,
      SRC_FAST_RC       = 2'b10,
      SRC_BUS2          = 2'b11
   } umcr_src_t;
   // Bus answers
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// ### rtl/umcr_clk_sel.sv
// Baud generator clock source selection and sleep gating.
// Source clocks arrive as one-cycle enable pulses in the clk domain.
`timescale 1ns/10ps
module umcr_clk_sel
   import umcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Control
   input  wire logic [1:0] srcSel,
   input  wire logic       runEnable,
   input  wire logic       sleepRun,
   input  wire logic       sleepMode,
   input  wire logic       deepSleepMode,
   // Source ticks
   input  wire logic       bus2Tick,
   input  wire logic       fastRcTick,
   input  wire logic       systemTick,
   // Gated baud tick
   output logic            baudTick
);
   typedef struct packed {
      logic tick;
   } umcr_cs_t;

   umcr_cs_t cur;
   umcr_cs_t next_cur;
   logic     srcTick;
   logic     allow;

   // Source mux and gating
   always_comb begin
      next_cur = cur;
      case (umcr_src_t'(srcSel))
         SRC_BUS2_SLEEPOFF: srcTick = bus2Tick;
         SRC_SYSTEM:        srcTick = systemTick;
         SRC_FAST_RC:       srcTick = fastRcTick;
         SRC_BUS2:          srcTick = bus2Tick;
         default:           srcTick = 1'b0;
      endcase
      allow = runEnable & ~deepSleepMode;
      if (sleepMode) begin
         allow = allow & sleepRun & (srcSel == SRC_FAST_RC);
      end
      next_cur.tick = srcTick & allow;
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign baudTick = cur.tick;
endmodule

// ### rtl/umcr_pin_ctrl.sv
// Pin ownership between the serial port and the general-purpose port.
// Pin 0 carries transmit, pin 1 carries receive; remap map flags come from outside.
`timescale 1ns/10ps
module umcr_pin_ctrl
   import umcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Control
   input  wire logic       moduleOn,
   input  wire logic       transmitEnable,
   input  wire logic       remapTx,
   input  wire logic       remapRx,
   input  wire logic       rxInvert,
   input  wire logic       txData,
   // General-purpose port
   input  wire logic [1:0] portLatch,
   input  wire logic [1:0] portDirection,
   input  wire logic [1:0] pinIn,
   // Pins and receive data
   output logic      [1:0] pinOut,
   output logic      [1:0] pinOe,
   output logic      [1:0] portPinValue,
   output logic            rxData
);
   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe;
      logic [1:0] value;
      logic       rx;
   } umcr_pc_t;

   umcr_pc_t cur;
   umcr_pc_t next_cur;

   // Ownership decision from moduleOn and the remap flags; the legacy field is not used
   always_comb begin
      next_cur       = cur;
      next_cur.out   = portLatch;
      next_cur.oe    = ~portDirection;
      next_cur.value = pinIn;
      next_cur.rx    = 1'b1;
      if (moduleOn && remapTx && transmitEnable) begin
         next_cur.out[0] = txData;
         next_cur.oe[0]  = 1'b1;
      end
      if (moduleOn && remapRx) begin
         next_cur.out[1] = 1'b0;
         next_cur.oe[1]  = 1'b0;
         next_cur.rx     = pinIn[1] ^ rxInvert;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '{out: 2'h0, oe: 2'h0, value: 2'h0, rx: 1'b1};
      end else begin
         cur <= next_cur;
      end
   end

   assign pinOut       = cur.out;
   assign pinOe        = cur.oe;
   assign portPinValue = cur.value;
   assign rxData       = cur.rx;
endmodule

// ### rtl/umcr_mode_ctrl.sv
// Serial port mode and control register with its AXI4-Lite slave.
// Assumes power-state flags, busy flags and source ticks synchronous to clk.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module umcr_mode_ctrl
   import umcr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic      [1:0]  s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   // AXI4-Lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   // Device power state
   input  wire logic        sleepMode,
   input  wire logic        idleMode,
   input  wire logic        deepSleepMode,
   // Baud clock sources
   input  wire logic        bus2Tick,
   input  wire logic        fastRcTick,
   input  wire logic        systemTick,
   // Serial port status
   input  wire logic        txBusy,
   input  wire logic        rxBusy,
   input  wire logic        receiveOverrunError,
   input  wire logic        transmitEnableBit,
   input  wire logic        txData,
   // Remap and general-purpose port
   input  wire logic        remapTx,
   input  wire logic        remapRx,
   input  wire logic [1:0]  portLatch,
   input  wire logic [1:0]  portDirection,
   input  wire logic [1:0]  pinIn,
   // Pins
   output logic      [1:0]  pinOut,
   output logic      [1:0]  pinOe,
   output logic      [1:0]  portPinValue,
   output logic             rxData,
   // Control to the serial port
   output logic             baudTick,
   output logic             portRunning,
   output logic             rxShiftEnable,
   output logic             wakeEnable,
   output logic             loopbackEnable,
   output logic             autoBaudEnable,
   output logic             highSpeedBaudSelect,
   output logic      [1:0]  parityWidthSelect,
   output logic             stopBitSelect,
   output logic             infraredEncoderEnable,
   output logic             requestToSendMode,
   output logic      [1:0]  legacyPinEnable
);
   typedef struct packed {
      logic [31:0] mode;
      logic        active;
      logic        run;
      logic        shiftEn;
      logic        awHeld;
      logic [7:0]  awAddr;
      logic        wHeld;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bValid;
      logic [1:0]  bResp;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
      logic        awReady;
      logic        wReady;
      logic        arReady;
   } umcr_st_t;

   umcr_st_t    cur;
   umcr_st_t    next_cur;
   logic [31:0] byteMask;
   logic [31:0] writeMask;
   logic        sleepRun;
   logic        moduleOn;
   logic        idleStop;
   logic        runOnOverrun;
   logic        rxInvert;
   logic [1:0]  srcSel;

   // Field views of the stored mode word
   assign sleepRun              = cur.mode[SLEEP_RUN_POS];
   assign srcSel                = cur.mode[CLK_SRC_HI_POS:CLK_SRC_LO_POS];
   assign runOnOverrun          = cur.mode[RUN_OVR_POS];
   assign moduleOn              = cur.mode[MODULE_ON_POS];
   assign idleStop              = cur.mode[IDLE_STOP_POS];
   assign rxInvert              = cur.mode[RX_INVERT_POS];
   assign infraredEncoderEnable = cur.mode[IR_ENABLE_POS];
   assign requestToSendMode     = cur.mode[RTS_MODE_POS];
   assign legacyPinEnable       = cur.mode[PIN_EN_HI_POS:PIN_EN_LO_POS];
   assign wakeEnable            = cur.mode[WAKE_POS];
   assign loopbackEnable        = cur.mode[LOOPBACK_POS];
   assign autoBaudEnable        = cur.mode[AUTO_BAUD_POS];
   assign highSpeedBaudSelect   = cur.mode[HIGH_SPEED_POS];
   assign parityWidthSelect     = cur.mode[PARITY_HI_POS:PARITY_LO_POS];
   assign stopBitSelect         = cur.mode[STOP_BIT_POS];

   // Byte-lane mask from the write strobes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byteMask[i*8 +: 8] = {8{cur.wStrb[i]}};
      end
      writeMask = byteMask & MODE_WRITE_MASK;
   end

   // Bus slave, mode register and run control
   always_comb begin
      next_cur = cur;
      // Address and data are taken in either order and held
      if (s_axi_awvalid && !cur.awHeld && !cur.bValid) begin
         next_cur.awHeld = 1'b1;
         next_cur.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur.wHeld && !cur.bValid) begin
         next_cur.wHeld = 1'b1;
         next_cur.wData = s_axi_wdata;
         next_cur.wStrb = s_axi_wstrb;
      end
      // Write commits once both halves are held
      if (cur.awHeld && cur.wHeld) begin
         next_cur.awHeld = 1'b0;
         next_cur.wHeld  = 1'b0;
         next_cur.bValid = 1'b1;
         if (cur.awAddr[7:2] == MODE_OFFSET[7:2]) begin
            next_cur.mode  = (cur.mode & ~writeMask) | (cur.wData & writeMask);
            next_cur.bResp = RESP_OKAY;
         end else begin
            next_cur.bResp = RESP_SLVERR;
         end
      end
      if (cur.bValid && s_axi_bready) begin
         next_cur.bValid = 1'b0;
      end
      // Read answers one cycle after the address is taken
      if (cur.rValid && s_axi_rready) begin
         next_cur.rValid = 1'b0;
      end
      if (s_axi_arvalid && !cur.rValid) begin
         next_cur.rValid = 1'b1;
         if (s_axi_araddr[7:2] == MODE_OFFSET[7:2]) begin
            next_cur.rData = cur.mode & MODE_WRITE_MASK;
            next_cur.rData[ACTIVE_POS] = cur.active;
            next_cur.rResp = RESP_OKAY;
         end else begin
            next_cur.rData = 32'h0000_0000;
            next_cur.rResp = RESP_SLVERR;
         end
      end
      // Port runs when enabled, not deep asleep and not halted in idle
      next_cur.run = moduleOn & ~deepSleepMode & ~(idleMode & idleStop);
      // Activity flag set while the port runs and transmit or receive is busy
      next_cur.active = next_cur.run & (txBusy | rxBusy);
      // Receive shifter after an overrun
      if (receiveOverrunError && !runOnOverrun) begin
         next_cur.shiftEn = 1'b0;
      end else begin
         next_cur.shiftEn = next_cur.run;
      end
      // Ready flags held in flops so the bus outputs carry no gate
      next_cur.awReady = ~next_cur.awHeld & ~next_cur.bValid;
      next_cur.wReady  = ~next_cur.wHeld & ~next_cur.bValid;
      next_cur.arReady = ~next_cur.rValid;
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         cur         <= '0;
         cur.mode    <= MODE_RESET;
         cur.awReady <= 1'b1;
         cur.wReady  <= 1'b1;
         cur.arReady <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // Baud clock source and sleep gating
   umcr_clk_sel u_clk_sel (
      .clk           (clk),
      .rst           (rst),
      .srcSel        (srcSel),
      .runEnable     (cur.run),
      .sleepRun      (sleepRun),
      .sleepMode     (sleepMode),
      .deepSleepMode (deepSleepMode),
      .bus2Tick      (bus2Tick),
      .fastRcTick    (fastRcTick),
      .systemTick    (systemTick),
      .baudTick      (baudTick)
   );

   // Pin ownership
   umcr_pin_ctrl u_pin_ctrl (
      .clk            (clk),
      .rst            (rst),
      .moduleOn       (moduleOn),
      .transmitEnable (transmitEnableBit),
      .remapTx        (remapTx),
      .remapRx        (remapRx),
      .rxInvert       (rxInvert),
      .txData         (txData),
      .portLatch      (portLatch),
      .portDirection  (portDirection),
      .pinIn          (pinIn),
      .pinOut         (pinOut),
      .pinOe          (pinOe),
      .portPinValue   (portPinValue),
      .rxData         (rxData)
   );

   // Bus outputs
   assign s_axi_awready = cur.awReady;
   assign s_axi_wready  = cur.wReady;
   assign s_axi_bvalid  = cur.bValid;
   assign s_axi_bresp   = cur.bResp;
   assign s_axi_arready = cur.arReady;
   assign s_axi_rvalid  = cur.rValid;
   assign s_axi_rdata   = cur.rData;
   assign s_axi_rresp   = cur.rResp;
   assign portRunning   = cur.run;
   assign rxShiftEnable = cur.shiftEn;
endmodule

// ### bench/umcr_mode_ctrl_monitor.sv
// Concurrent checks on the mode register block's ports.
// Bound to umcr_mode_ctrl; single clock, synchronous reset.
`timescale 1ns/10ps
module umcr_mode_ctrl_monitor
   import umcr_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Power state and ticks
   input wire logic        sleepMode,
   input wire logic        deepSleepMode,
   input wire logic        bus2Tick,
   input wire logic        fastRcTick,
   input wire logic        systemTick,
   // Control outputs
   input wire logic        baudTick,
   input wire logic        portRunning,
   input wire logic        rxShiftEnable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Both write halves taken on one edge
   sequence wrTake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTake;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // Bus answers and their holding
   write_resp_a: assert property (wrTake |-> ##2 s_axi_bvalid)
      else $error("write answer not on time");
   read_resp_a: assert property (rdTake |=> s_axi_rvalid)
      else $error("read answer not on time");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   reserved_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFF38_4000) == 32'h0)
      else $error("unimplemented bits read nonzero");
   // Power gating of the port and its baud clock
   deep_stop_a: assert property (deepSleepMode |=> !portRunning && !rxShiftEnable)
      else $error("port runs in deep sleep");
   tick_source_a: assert property (baudTick |-> ($past(bus2Tick) || $past(fastRcTick) || $past(systemTick)) && !$past(deepSleepMode))
      else $error("baud tick without source");
   sleep_gate_a: assert property (baudTick && $past(sleepMode) |-> $past(fastRcTick))
      else $error("sleep tick not from fast RC");
   shift_run_a: assert property (rxShiftEnable |-> portRunning)
      else $error("shifter runs while port stopped");
endmodule

bind umcr_mode_ctrl umcr_mode_ctrl_monitor u_mon (.*);

// ### bench/umcr_mode_ctrl_tb.sv
// Self-checking bench for the mode register block.
// Drives every port directly; registers reached over AXI4-Lite.
`timescale 1ns/10ps
module umcr_mode_ctrl_tb;
   import umcr_pkg::*;
   // Design signals
   logic        clk = 1'b0, rst = 1'b1;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [3:0]  s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        sleepMode, idleMode, deepSleepMode, bus2Tick, fastRcTick, systemTick;
   logic        txBusy, rxBusy, receiveOverrunError, transmitEnableBit, txData;
   logic        remapTx, remapRx, rxData, baudTick, portRunning, rxShiftEnable;
   logic [1:0]  portLatch, portDirection, pinIn, pinOut, pinOe, portPinValue;
   logic        wakeEnable, loopbackEnable, autoBaudEnable, highSpeedBaudSelect;
   logic        stopBitSelect, infraredEncoderEnable, requestToSendMode;
   logic [1:0]  parityWidthSelect, legacyPinEnable;
   // Bench state
   int          badCount = 0, samplesChecked = 0, c;
   logic [31:0] v, w;
   int          srcMap[4] = '{0, 2, 1, 0};
   logic [31:0] slpD[4] = '{32'h0084_8000, 32'h0004_8000, 32'h0086_8000, 32'h0084_8000};
   logic [2:0]  slpT[4] = '{3'h2, 3'h2, 3'h4, 3'h2};

   umcr_mode_ctrl u_dut (.*);

   // Clock
   always #12.5 clk = ~clk;

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         badCount++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Write both halves together, wait for the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic       awr, wrd, bv;
      logic [1:0] resp;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      // Sample the handshake at mid-cycle, act on the following edge
      do begin
         @(negedge clk);
         awr = s_axi_awvalid & s_axi_awready;
         wrd = s_axi_wvalid & s_axi_wready;
         bv = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clk);
         if (awr) s_axi_awvalid <= 1'b0;
         if (wrd) s_axi_wvalid <= 1'b0;
      end while (bv !== 1'b1);
      check(32'(resp), 32'(r));
      s_axi_bready <= 1'b0;
   endtask

   // Read one word, wait for the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
      logic       arr, rv;
      logic [1:0] resp;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(negedge clk);
         arr = s_axi_arvalid & s_axi_arready;
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clk);
         if (arr) s_axi_arvalid <= 1'b0;
      end while (rv !== 1'b1);
      check(32'(resp), 32'(r));
      s_axi_rready <= 1'b0;
   endtask

   task automatic rdc(input logic [31:0] e);
      rd(MODE_OFFSET, v, RESP_OKAY);
      check(v, e);
   endtask

   // Pulse one source tick, count baud ticks
   task automatic tick(input logic [2:0] sel, output int cnt);
      cnt = 0;
      @(posedge clk);
      {bus2Tick, fastRcTick, systemTick} <= sel;
      @(posedge clk);
      {bus2Tick, fastRcTick, systemTick} <= 3'h0;
      repeat (4) begin
         @(negedge clk);
         if (baudTick !== 1'b0) cnt++;
      end
      @(posedge clk);
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      conclude();
   end

   // Main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
      s_axi_wstrb = 4'hF;
      {sleepMode, idleMode, deepSleepMode, bus2Tick, fastRcTick, systemTick} = '0;
      {txBusy, rxBusy, receiveOverrunError, transmitEnableBit, txData} = '0;
      {remapTx, remapRx, portLatch, portDirection, pinIn} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // Reset value, writable mask, field outputs
      rdc(MODE_RESET);
      wr(MODE_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
      rdc(MODE_WRITE_MASK);
      for (int p = 0; p < 2; p++) begin
         w = p ? 32'h0000_05AA : 32'h0000_1A55;
         wr(MODE_OFFSET, w, RESP_OKAY);
         cyc(2);
         check(32'({infraredEncoderEnable, requestToSendMode, legacyPinEnable, wakeEnable,
                    loopbackEnable, autoBaudEnable, highSpeedBaudSelect, parityWidthSelect,
                    stopBitSelect}), 32'({w[12:11], w[9:5], w[3:0]}));
         rdc(p ? 32'h0000_01AA : 32'h0000_1A55);
      end
      // Unmapped word refused and harmless
      wr(8'h04, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(8'h04, v, RESP_SLVERR);
      check(v, 32'h0);
      rdc(32'h0000_01AA);
      // Each source code picks its own tick
      for (int s = 0; s < 4; s++) begin
         wr(MODE_OFFSET, 32'h8000 | 32'(s << 17), RESP_OKAY);
         cyc(4);
         for (int k = 0; k < 3; k++) begin
            tick(3'h4 >> k, c);
            check(32'(c), 32'(srcMap[s] == k));
         end
      end
      // Sleep gating, then deep sleep
      sleepMode <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         deepSleepMode <= (i == 3);
         wr(MODE_OFFSET, slpD[i], RESP_OKAY);
         cyc(4);
         tick(slpT[i], c);
         check(32'(c), 32'(i == 0));
      end
      // Activity flag and idle stop
      {sleepMode, deepSleepMode, txBusy} <= 3'h1;
      wr(MODE_OFFSET, 32'h0040_A000, RESP_OKAY);
      cyc(3);
      rdc(32'h0040_A000);
      check(32'(portRunning), 32'h1);
      idleMode <= 1'b1;
      cyc(3);
      check(32'(portRunning), 32'h0);
      rdc(32'h0000_A000);
      wr(MODE_OFFSET, 32'h0000_8000, RESP_OKAY);
      {txBusy, rxBusy} <= 2'h1;
      cyc(3);
      check(32'(portRunning), 32'h1);
      rdc(32'h0040_8000);
      // Overrun with and without run-on-overrun
      {rxBusy, receiveOverrunError} <= 2'h1;
      cyc(3);
      check(32'(rxShiftEnable), 32'h0);
      wr(MODE_OFFSET, 32'h0001_8000, RESP_OKAY);
      cyc(3);
      check(32'(rxShiftEnable), 32'h1);
      // Pin ownership: off, on with remap, on without remap
      {idleMode, receiveOverrunError} <= 2'h0;
      {remapTx, remapRx, transmitEnableBit, txData} <= 4'hF;
      {portLatch, portDirection, pinIn} <= 6'b10_01_10;
      wr(MODE_OFFSET, 32'h0000_0300, RESP_OKAY);
      cyc(4);
      check(32'({pinOut, pinOe, rxData}), 32'h15);
      check(32'(portPinValue), 32'h2);
      wr(MODE_OFFSET, 32'h0000_8310, RESP_OKAY);
      cyc(4);
      check(32'({pinOut, pinOe, rxData}), 32'h0A);
      {remapTx, remapRx} <= 2'h0;
      cyc(4);
      check(32'({pinOut, pinOe, rxData}), 32'h15);
      check(32'(legacyPinEnable), 32'h3);
      conclude();
   end
endmodule
